// ===== core/flotp_pkg.sv
// Constants and carrier types for the flash lock and OTP access block.
// Assumes an SPI mode 0 host and a 20 MHz core clock.
// Operation
// - Hardware lock is active only with protect pin asserted and lock bit 1.
// - Under hardware lock, sector commands and status writes are ignored.
// - Unlocking needs pin released, then a status write; no global action then.
// - With pin held asserted, a set lock bit clears only by reset.
// - Pin released: status write may set lock and apply global from bits 5:2.
// - Sector protection follows only its register; pin has no direct effect.
// - Lock bit 0: lock may rise, protection registers stay modifiable.
// - Software lock: lock bit may fall, protection registers stay frozen.
// - Security register is 128 bytes: 64 user, 64 fixed factory bytes.
// - No erase needed; user part can be programmed only once.
// - Program is 9Bh, three address bytes, data; address bits 23:6 ignored.
// - Data past the end of the 64-byte user part wraps to offset 0.
// - More than 64 data bytes keeps only the last 64.
// - Chip select release programs sent bytes; unsent bytes stay FFh.
// - Short address, no whole data byte or odd release aborts program.
// - An aborted or refused program clears the write latch flag.
// - Busy shows while programming; write latch flag clears before it ends.
// - Programming goes through the shared page buffer, overwriting it.
// - Read is 77h, three address bytes, two dummy bytes, then data.
// - Reading past the last byte continues at 0 with no gap.
// - Chip select release ends a read and floats the output at once.
// - Lock bit is 0 after power-up and after device reset.
// - Status write stores only bit 7; bits 5:2 are decoded only.
`default_nettype none

package flotp_pkg;
	// Opcodes.
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_WRSR      = 8'h01;
	localparam logic [7:0] OP_PROTECT   = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam logic [7:0] OP_OTP_PROG  = 8'h9b;
	localparam logic [7:0] OP_OTP_READ  = 8'h77;
	// Status byte fields.
	localparam int         LOCK_POS     = 7;
	localparam int         GLOBAL_HI    = 5;
	localparam int         GLOBAL_LO    = 2;
	localparam logic [3:0] GLOBAL_PROT  = 4'hf;
	localparam logic [3:0] GLOBAL_UNPR  = 4'h0;
	// Frame byte positions, counted in completed bytes.
	localparam logic [2:0] BC_OPCODE    = 3'h0;
	localparam logic [2:0] BC_ADDR_HI   = 3'h1;
	localparam logic [2:0] BC_ADDR_MID  = 3'h2;
	localparam logic [2:0] BC_ADDR_LO   = 3'h3;
	localparam logic [2:0] BC_DATA      = 3'h4;
	localparam logic [2:0] BC_READ_DATA = 3'h6;
	localparam logic [2:0] BC_MAX       = 3'h7;
	// Security register and sector layout.
	localparam int         USER_BYTES   = 64;
	localparam int         SECTOR_SHIFT = 16;
	localparam logic [7:0] ERASED       = 8'hff;
	localparam logic       SECT_RESET   = 1'b1;
	// Program time.
	localparam int         SECURE_PROGRAM_TIME_NS = 500000;
	localparam int         CORE_PERIOD_NS         = 50;
	localparam int         SECURE_PROGRAM_CYCLES  =
		(SECURE_PROGRAM_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

	// Command frame as captured on the link clock.
	typedef struct packed {
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  stat;
		logic [2:0]  byte_cnt;
		logic [2:0]  bit_pos;
	} flotp_frame_t;

	// Program sequencer states, Gray coded.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COPY = 2'b01,
		ST_WAIT = 2'b11
	} flotp_state_t;
endpackage

`default_nettype wire

// ===== core/flotp_core.sv
// Lock state, sector protection registers and security register access.
// Assumes an SPI mode 0 host; the link clock stops outside frames.
`default_nettype none

module flotp_core #(
	parameter int           SECTORS     = 4,
	parameter int           PROG_CYCLES = flotp_pkg::SECURE_PROGRAM_CYCLES,
	// Factory bytes; the value is arbitrary.
	parameter logic [511:0] SERIAL_IDENTITY_STORAGE =
		{8{64'h5a3c_96e1_0f87_d24b}}
) (
	// Core clock and reset.
	input  wire logic               CORE_CLK_I,
	input  wire logic               RST_I,
	// SPI link.
	input  wire logic               SPI_CLK_I,
	input  wire logic               SPI_CS_N_I,
	input  wire logic               SPI_SI_I,
	output var  logic               SPI_SO_O,
	output var  logic               SPI_SO_OE_O,
	// Protect pin.
	input  wire logic               WP_N_I,
	// Lock, latch and program state.
	output var  logic               PROTECTION_REGS_LOCKED_BIT_O,
	output var  logic               HW_LOCKED_O,
	output var  logic               WRITE_LATCH_FLAG_O,
	output var  logic               BUSY_O,
	output var  logic               OTP_USED_O,
	output var  logic [SECTORS-1:0] SECT_PROT_O
);
	localparam int SIDX = (SECTORS > 1) ? $clog2(SECTORS) : 1;
	localparam int TW   = $clog2(PROG_CYCLES + 1);

	//------------------------------------------------------------
	// Link clock domain
	//------------------------------------------------------------

	flotp_pkg::flotp_frame_t frame;
	logic                    first;
	logic                    frame_tog;
	logic [6:0]              shift;
	logic [2:0]              bi;
	logic [2:0]              bc;
	logic [7:0]              byte_in;
	logic                    byte_done;
	logic [6:0]              ptr;
	logic                    ptr_step;
	logic [7:0]              page_buf [flotp_pkg::USER_BYTES];
	logic [63:0]             mask;
	logic [7:0]              rd_byte;
	logic                    rd_phase;
	logic [6:0]              out_sh;
	logic [7:0]              otp_user [flotp_pkg::USER_BYTES];

	// Marks the first clock of a frame; chip select high presets it.
	always_ff @(posedge SPI_CLK_I or posedge SPI_CS_N_I) begin
		if (SPI_CS_N_I) begin
			first <= 1'b1;
		end else begin
			first <= 1'b0;
		end
	end

	// Bit and byte position as seen on this edge.
	always_comb begin
		bi        = first ? 3'h0 : frame.bit_pos;
		bc        = first ? 3'h0 : frame.byte_cnt;
		byte_in   = {shift, SPI_SI_I};
		byte_done = (bi == 3'h7);
		rd_phase  = (frame.opcode == flotp_pkg::OP_OTP_READ) &&
			(frame.byte_cnt >= flotp_pkg::BC_READ_DATA);
		ptr_step  = byte_done && (bc >= ((frame.opcode ==
			flotp_pkg::OP_OTP_READ) ? flotp_pkg::BC_READ_DATA :
			flotp_pkg::BC_DATA));
	end

	// Toggles once per frame so the core can tell a new frame from none.
	always_ff @(posedge SPI_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			frame_tog <= 1'b0;
		end else if (first) begin
			frame_tog <= ~frame_tog;
		end
	end

	// Shifts in the opcode, address and status byte; holds after the frame.
	always_ff @(posedge SPI_CLK_I) begin
		shift         <= byte_in[6:0];
		frame.bit_pos <= bi + 3'h1;
		frame.byte_cnt <= (byte_done && bc != flotp_pkg::BC_MAX) ?
			bc + 3'h1 : bc;
		if (byte_done) begin
			case (bc)
				flotp_pkg::BC_OPCODE: begin
					frame.opcode <= byte_in;
				end
				flotp_pkg::BC_ADDR_HI: begin
					frame.addr[23:16] <= byte_in;
					frame.stat        <= byte_in;
				end
				flotp_pkg::BC_ADDR_MID: begin
					frame.addr[15:8] <= byte_in;
				end
				flotp_pkg::BC_ADDR_LO: begin
					frame.addr[7:0] <= byte_in;
				end
				default: begin
				end
			endcase
		end
	end

	// Fills the page buffer; the low seven address bits load the pointer, the low six index the buffer.
	always_ff @(posedge SPI_CLK_I) begin
		if (byte_done && bc == flotp_pkg::BC_ADDR_LO) begin
			ptr  <= byte_in[6:0];
			mask <= '0;
		end else if (ptr_step) begin
			ptr <= ptr + 7'h1;
			if (frame.opcode == flotp_pkg::OP_OTP_PROG) begin
				page_buf[ptr[5:0]] <= byte_in;
				mask[ptr[5:0]]     <= 1'b1;
			end
		end
	end

	// Read source; user bytes only change on reset or while a program runs.
	always_comb begin
		if (ptr[6]) begin
			rd_byte = SERIAL_IDENTITY_STORAGE[{ptr[5:0], 3'h0} +: 8];
		end else begin
			rd_byte = otp_user[ptr[5:0]];
		end
	end

	// Drives serial output on falling edges; chip select floats it.
	always_ff @(negedge SPI_CLK_I or posedge SPI_CS_N_I) begin
		if (SPI_CS_N_I) begin
			SPI_SO_OE_O <= 1'b0;
			SPI_SO_O    <= 1'b0;
		end else if (rd_phase) begin
			SPI_SO_OE_O <= 1'b1;
			if (frame.bit_pos == 3'h0) begin
				SPI_SO_O <= rd_byte[7];
			end else begin
				SPI_SO_O <= out_sh[6];
			end
		end
	end

	// Holds the rest of the byte being shifted out.
	always_ff @(negedge SPI_CLK_I) begin
		if (frame.bit_pos == 3'h0) begin
			out_sh <= rd_byte[6:0];
		end else begin
			out_sh <= {out_sh[5:0], 1'b0};
		end
	end

	//------------------------------------------------------------
	// Core clock domain
	//------------------------------------------------------------

	logic                    cs_s1;
	logic                    cs_s2;
	logic                    tog_s1;
	logic                    tog_s2;
	logic                    wp_s1;
	logic                    wp_s2;
	logic                    tog_seen;
	logic                    pending;
	logic                    exec;
	logic                    cmd_ok;
	logic                    aligned;
	logic                    hw_lock;
	logic                    do_wren;
	logic                    do_wrdi;
	logic                    do_wrsr;
	logic                    do_sect;
	logic                    prog_try;
	logic                    prog_ok;
	logic                    prog_abort;
	logic [SIDX-1:0]         sect_idx;
	logic                    protection_regs_locked_bit;
	logic                    write_latch_flag;
	logic [SECTORS-1:0]      sect_prot;
	logic                    otp_used;
	logic [TW-1:0]           timer;
	flotp_pkg::flotp_state_t state;
	flotp_pkg::flotp_state_t next_state;

	// Two-flop synchronisers for chip select, frame toggle and protect pin.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			wp_s1  <= 1'b1;
			wp_s2  <= 1'b1;
		end else begin
			cs_s1  <= SPI_CS_N_I;
			cs_s2  <= cs_s1;
			tog_s1 <= frame_tog;
			tog_s2 <= tog_s1;
			wp_s1  <= WP_N_I;
			wp_s2  <= wp_s1;
		end
	end

	// A frame runs once chip select was seen low, then high again.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pending  <= 1'b0;
			tog_seen <= 1'b0;
		end else if (!cs_s2) begin
			pending <= 1'b1;
		end else if (pending) begin
			pending  <= 1'b0;
			tog_seen <= tog_s2;
		end
	end

	// Command decode; frame words are stable once chip select is high.
	always_comb begin
		exec     = cs_s2 && pending && (tog_s2 != tog_seen);
		cmd_ok   = exec && (state == flotp_pkg::ST_IDLE);
		aligned  = (frame.bit_pos == 3'h0);
		hw_lock  = !wp_s2 && protection_regs_locked_bit;
		sect_idx = frame.addr[flotp_pkg::SECTOR_SHIFT +: SIDX];
		do_wren  = cmd_ok && frame.opcode == flotp_pkg::OP_WREN;
		do_wrdi  = cmd_ok && frame.opcode == flotp_pkg::OP_WRDI;
		do_wrsr  = cmd_ok && frame.opcode == flotp_pkg::OP_WRSR &&
			aligned && frame.byte_cnt >= flotp_pkg::BC_ADDR_MID &&
			write_latch_flag;
		do_sect  = cmd_ok && aligned && write_latch_flag &&
			frame.byte_cnt >= flotp_pkg::BC_DATA &&
			(frame.opcode == flotp_pkg::OP_PROTECT ||
			frame.opcode == flotp_pkg::OP_UNPROTECT);
		prog_try = cmd_ok && frame.opcode == flotp_pkg::OP_OTP_PROG &&
			write_latch_flag;
		prog_ok  = prog_try && aligned && !otp_used &&
			frame.byte_cnt > flotp_pkg::BC_DATA;
		prog_abort = prog_try && !prog_ok;
	end

	// Lock bit: only bit 7 of a status write is stored.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			protection_regs_locked_bit <= 1'b0;
		end else if (do_wrsr && !hw_lock) begin
			protection_regs_locked_bit <=
				frame.stat[flotp_pkg::LOCK_POS];
		end
	end

	// Sector protection registers; frozen whenever the lock bit is 1.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			sect_prot <= {SECTORS{flotp_pkg::SECT_RESET}};
		end else if (do_wrsr && !protection_regs_locked_bit) begin
			if (frame.stat[flotp_pkg::GLOBAL_HI:flotp_pkg::GLOBAL_LO] ==
				flotp_pkg::GLOBAL_PROT) begin
				sect_prot <= '1;
			end else if (frame.stat[flotp_pkg::GLOBAL_HI:
				flotp_pkg::GLOBAL_LO] == flotp_pkg::GLOBAL_UNPR) begin
				sect_prot <= '0;
			end
		end else if (do_sect && !protection_regs_locked_bit) begin
			sect_prot[sect_idx] <=
				(frame.opcode == flotp_pkg::OP_PROTECT);
		end
	end

	// Write latch flag; any program attempt clears it at the start.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			write_latch_flag <= 1'b0;
		end else if (do_wren) begin
			write_latch_flag <= 1'b1;
		end else if (do_wrdi || do_wrsr || do_sect || prog_try) begin
			write_latch_flag <= 1'b0;
		end
	end

	// Program sequencer next state.
	always_comb begin
		next_state = state;
		case (state)
			flotp_pkg::ST_IDLE: begin
				if (prog_ok) begin
					next_state = flotp_pkg::ST_COPY;
				end
			end
			flotp_pkg::ST_COPY: begin
				next_state = flotp_pkg::ST_WAIT;
			end
			flotp_pkg::ST_WAIT: begin
				if (timer <= TW'(1)) begin
					next_state = flotp_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = flotp_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer state and self-timed program counter.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state <= flotp_pkg::ST_IDLE;
			timer <= '0;
		end else begin
			state <= next_state;
			if (state == flotp_pkg::ST_COPY) begin
				timer <= TW'(PROG_CYCLES);
			end else if (timer != '0) begin
				timer <= timer - TW'(1);
			end
		end
	end

	// User bytes; reset stands in for a blank part.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			otp_used <= 1'b0;
			for (int i = 0; i < flotp_pkg::USER_BYTES; i++) begin
				otp_user[i] <= flotp_pkg::ERASED;
			end
		end else if (state == flotp_pkg::ST_COPY) begin
			otp_used <= 1'b1;
			for (int i = 0; i < flotp_pkg::USER_BYTES; i++) begin
				if (mask[i]) begin
					otp_user[i] <= page_buf[i];
				end
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			PROTECTION_REGS_LOCKED_BIT_O <= 1'b0;
			HW_LOCKED_O                  <= 1'b0;
			WRITE_LATCH_FLAG_O           <= 1'b0;
			BUSY_O                       <= 1'b0;
			OTP_USED_O                   <= 1'b0;
			SECT_PROT_O <= {SECTORS{flotp_pkg::SECT_RESET}};
		end else begin
			PROTECTION_REGS_LOCKED_BIT_O <= protection_regs_locked_bit;
			HW_LOCKED_O                  <= hw_lock;
			WRITE_LATCH_FLAG_O           <= write_latch_flag;
			BUSY_O <= (next_state != flotp_pkg::ST_IDLE);
			OTP_USED_O                   <= otp_used;
			SECT_PROT_O                  <= sect_prot;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	property p_hw_lock;
		HW_LOCKED_O |-> $past(protection_regs_locked_bit) && !$past(wp_s2);
	endproperty
	a_hw_lock: assert property (p_hw_lock)
		else $error("Hardware lock shown without its two causes.");

	property p_hw_ignore;
		do_wrsr && hw_lock |=> $stable(protection_regs_locked_bit) &&
			$stable(sect_prot);
	endproperty
	a_hw_ignore: assert property (p_hw_ignore)
		else $error("Status write changed state under hardware lock.");

	property p_unlock_no_global;
		do_wrsr && protection_regs_locked_bit && !hw_lock |=>
			$stable(sect_prot) && !protection_regs_locked_bit ==
			!$past(frame.stat[7]);
	endproperty
	a_unlock_no_global: assert property (p_unlock_no_global)
		else $error("Unlocking write changed protection registers.");

	property p_global_prot;
		do_wrsr && !protection_regs_locked_bit &&
			frame.stat[5:2] == 4'hf |=> ##1 (&SECT_PROT_O);
	endproperty
	a_global_prot: assert property (p_global_prot)
		else $error("Global protect did not set every sector.");

	property p_soft_frozen;
		do_sect && protection_regs_locked_bit |=> $stable(sect_prot)[*2];
	endproperty
	a_soft_frozen: assert property (p_soft_frozen)
		else $error("Sector command changed a locked register.");

	property p_once;
		prog_try && otp_used |=> state == flotp_pkg::ST_IDLE &&
			!write_latch_flag;
	endproperty
	a_once: assert property (p_once)
		else $error("Second program of the user part was accepted.");

	property p_abort_wel;
		prog_abort |=> !write_latch_flag ##1 !WRITE_LATCH_FLAG_O &&
			!BUSY_O;
	endproperty
	a_abort_wel: assert property (p_abort_wel)
		else $error("Aborted program left latch set or went busy.");

	// The latch output trails the internal flag by one edge.
	property p_busy;
		prog_ok |=> BUSY_O && !write_latch_flag ##1 BUSY_O &&
			!WRITE_LATCH_FLAG_O;
	endproperty
	a_busy: assert property (p_busy)
		else $error("Program did not show busy with latch cleared.");

	property p_reset_lock;
		@(posedge CORE_CLK_I) disable iff (1'b0)
			RST_I |=> !protection_regs_locked_bit;
	endproperty
	a_reset_lock: assert property (p_reset_lock)
		else $error("Lock bit not cleared by reset.");

	c_hw_lock: cover property (do_wrsr && hw_lock);
	c_prog: cover property (prog_ok ##1 BUSY_O);
	c_abort: cover property (prog_abort);
	c_soft_unlock: cover property (do_wrsr && protection_regs_locked_bit
		&& wp_s2);
endmodule

`default_nettype wire

// ===== testbench/flotp_host_model.sv
// Host SPI controller model for the flash lock and OTP access block.
// Assumes mode 0 framing; the link clock runs only inside frames.
`default_nettype none

module flotp_host_model (
	// Link outputs.
	output var  logic spi_clk_o,
	output var  logic cs_n_o,
	output var  logic si_o,
	// Link inputs.
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	int oe_bad = 0;

	// Idle link: clock low, chip select released.
	// The release is a non-blocking update so that the link presets see an edge.
	initial begin
		spi_clk_o = 1'b0;
		cs_n_o <= 1'b1;
		si_o = 1'b0;
	end

	// Sends one bit; the 64 ns link clock is unrelated to the core clock.
	task automatic bit_out(input logic b);
		si_o = b;
		#32;
		spi_clk_o = 1'b1;
		#32;
		spi_clk_o = 1'b0;
	endtask

	// Sends whole bytes MSB first, then tail bits, then clocks in rd_bits.
	task automatic xfer(input logic [7:0] tx[$], input int tail,
		input int rd_bits, output logic [7:0] rx[$]);
		logic [7:0] v;
		int i;
		int j;
		rx = {};
		v = 8'h00;
		cs_n_o = 1'b0;
		#20;
		for (i = 0; i < tx.size(); i++) begin
			for (j = 7; j >= 0; j--) begin
				bit_out(tx[i][j]);
			end
		end
		for (j = 0; j < tail; j++) begin
			bit_out(j[0]);
		end
		// Data arrives on falling edges and is taken before the next rise.
		for (i = 0; i < rd_bits; i++) begin
			si_o = ~si_o;
			#32;
			v[7 - (i % 8)] = so_i;
			if (so_oe_i !== 1'b1) begin
				oe_bad++;
			end
			spi_clk_o = 1'b1;
			#32;
			spi_clk_o = 1'b0;
			if (i % 8 == 7) begin
				rx.push_back(v);
			end
		end
		#20;
		cs_n_o = 1'b1;
		#1;
		// Output must float as soon as the frame ends.
		if (so_oe_i !== 1'b0) begin
			oe_bad++;
		end
		si_o = 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== testbench/flotp_core_tb_top.sv
// Self-checking bench for the flash lock and OTP access block.
// Assumes the host model file is compiled first; core clock 20 MHz.
`default_nettype none

module flotp_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Clock, reset and design
	// ------------------------------------------------------------
	logic       core_clk = 1'b0;
	logic       rst;
	logic       wp_n = 1'b1;
	logic       sck;
	logic       cs_n;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       lock;
	logic       hw;
	logic       latch;
	logic       busy;
	logic       used;
	logic [3:0] sect;
	int         bad_count = 0;
	int         check_count = 0;
	logic [7:0] r[$];
	logic [7:0] q[$];
	// Factory bytes given to the design; the value is arbitrary.
	localparam logic [511:0] FACT_BYTES = {8{64'h1e2d_3c4b_5a69_7887}};

	// Core clock, 50 ns period.
	always #25 core_clk = ~core_clk;

	flotp_core #(
		.SECTORS                (4),
		.PROG_CYCLES            (8),
		.SERIAL_IDENTITY_STORAGE(FACT_BYTES)
	) u_flotp_core (
		.CORE_CLK_I                  (core_clk),
		.RST_I                       (rst),
		.SPI_CLK_I                   (sck),
		.SPI_CS_N_I                  (cs_n),
		.SPI_SI_I                    (si),
		.SPI_SO_O                    (so),
		.SPI_SO_OE_O                 (so_oe),
		.WP_N_I                      (wp_n),
		.PROTECTION_REGS_LOCKED_BIT_O(lock),
		.HW_LOCKED_O                 (hw),
		.WRITE_LATCH_FLAG_O          (latch),
		.BUSY_O                      (busy),
		.OTP_USED_O                  (used),
		.SECT_PROT_O                 (sect)
	);

	flotp_host_model u_flotp_host_model (
		.spi_clk_o(sck),
		.cs_n_o   (cs_n),
		.si_o     (si),
		.so_i     (so),
		.so_oe_i  (so_oe)
	);

	// ------------------------------------------------------------
	// Helper tasks
	// ------------------------------------------------------------
	// Prints the verdict and ends the run.
	task automatic close_out();
		if (bad_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		// Looks just after the edge, once the registered outputs settle.
		#1;
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// One frame, then enough core cycles for its effect to show.
	task automatic cmd(input logic [7:0] b[$]);
		logic [7:0] x[$];
		u_flotp_host_model.xfer(b, 0, 0, x);
		cyc(8);
	endtask

	task automatic wsr(input logic [7:0] v);
		cmd({flotp_pkg::OP_WREN});
		cmd({flotp_pkg::OP_WRSR, v, 8'h00});
	endtask

	task automatic sect_cmd(input logic [7:0] op, input logic [7:0] idx);
		cmd({flotp_pkg::OP_WREN});
		cmd({op, idx, 8'h00, 8'h00});
	endtask

	// Reads n security bytes from a start address.
	task automatic rd(input logic [7:0] a, input int n);
		u_flotp_host_model.xfer({flotp_pkg::OP_OTP_READ, 8'h00, 8'h00, a,
			8'h00, 8'h00}, 0, n * 8, r);
		cyc(5);
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 100 && busy !== 1'b0; k++) begin
			cyc(1);
		end
		chk(busy, 1'b0);
	endtask

	// Synchronous reset held for 3 core cycles.
	task automatic do_reset();
		@(posedge core_clk) rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		cyc(2);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		// A non-blocking rise at time zero gives the link reset flop an edge.
		rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		cyc(2);
		chk(lock, 1'b0);
		chk({hw, latch, busy, used, sect}, 8'h0f);
		cmd({flotp_pkg::OP_WREN});
		chk(latch, 1'b1);
		cmd({flotp_pkg::OP_UNPROTECT, 8'h01, 8'h00, 8'h00});
		chk({latch, sect}, 5'h0d);
		wsr(8'h80);
		chk({lock, sect}, 5'h10);
		sect_cmd(flotp_pkg::OP_PROTECT, 8'h02);
		chk({latch, sect}, 5'h00);
		@(posedge core_clk) wp_n <= 1'b0;
		cyc(6);
		chk(hw, 1'b1);
		wsr(8'h3c);
		chk({lock, sect}, 5'h10);
		sect_cmd(flotp_pkg::OP_PROTECT, 8'h00);
		chk(sect, 4'h0);
		do_reset();
		chk({lock, hw, sect}, 6'h0f);
		wsr(8'h80);
		chk({lock, sect}, 5'h10);
		@(posedge core_clk) wp_n <= 1'b1;
		cyc(6);
		chk(hw, 1'b0);
		wsr(8'h3c);
		chk({lock, sect}, 5'h00);
		wsr(8'hbc);
		chk({lock, sect}, 5'h1f);
		do_reset();
		cmd({flotp_pkg::OP_WREN});
		cmd({flotp_pkg::OP_OTP_PROG, 8'h00, 8'h00});
		chk({latch, busy, used}, 3'h0);
		cmd({flotp_pkg::OP_WREN});
		u_flotp_host_model.xfer({flotp_pkg::OP_OTP_PROG, 8'h00, 8'h00,
			8'h00, 8'h11}, 3, 0, q);
		cyc(8);
		chk({latch, busy, used}, 3'h0);
		cmd({flotp_pkg::OP_WREN});
		cmd({flotp_pkg::OP_OTP_PROG, 8'hff, 8'hff, 8'h3e,
			8'ha1, 8'ha2, 8'ha3});
		chk({busy, latch}, 2'h2);
		wait_idle();
		chk(used, 1'b1);
		rd(8'h3e, 2);
		chk({r[0], r[1]}, 16'ha1a2);
		rd(8'h7f, 4);
		chk(r[0], FACT_BYTES[511:504]);
		chk({r[1], r[2], r[3]}, 24'ha3ffff);
		cmd({flotp_pkg::OP_WREN});
		cmd({flotp_pkg::OP_OTP_PROG, 8'h00, 8'h00, 8'h00, 8'h55});
		chk({busy, latch}, 2'h0);
		rd(8'h00, 1);
		chk(r[0], 8'ha3);
		do_reset();
		rd(8'h7f, 1);
		chk(r[0], FACT_BYTES[511:504]);
		cmd({flotp_pkg::OP_WREN});
		q = {flotp_pkg::OP_OTP_PROG, 8'h00, 8'h00, 8'h40};
		for (int k = 0; k < 66; k++) begin
			q.push_back(8'(k));
		end
		cmd(q);
		wait_idle();
		rd(8'h00, 64);
		for (int k = 0; k < 64; k++) begin
			chk(r[k], (k < 2) ? 8'(k + 64) : 8'(k));
		end
		u_flotp_host_model.xfer({flotp_pkg::OP_OTP_READ, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00}, 0, 12, r);
		cyc(4);
		chk(u_flotp_host_model.oe_bad, 0);
		close_out();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		cyc(60000);
		bad_count++;
		close_out();
	end
endmodule

`default_nettype wire
